// >>> rtl/stpg_map.svh
/*
 * register indices, reset values and field positions of the test pattern block.
 * assumes byte address = index * 4 on a 32-bit register bus.
 */
`ifndef STPG_MAP_SVH
`define STPG_MAP_SVH

`define STPG_IDX_CTRL     6'h10
`define STPG_IDX_SPARE_A  6'h11
`define STPG_IDX_LOW01    6'h12
`define STPG_IDX_LOW23    6'h13
`define STPG_IDX_SPARE_B  6'h14
`define STPG_IDX_SPARE_C  6'h15
`define STPG_IDX_HIGH     6'h16
`define STPG_IDX_STATUS   6'h17

`define STPG_RST_CTRL     16'h0000
`define STPG_RST_SPARE_A  16'h0000
`define STPG_RST_LOW01    16'h0100
`define STPG_RST_LOW23    16'h0302
`define STPG_RST_SPARE_B  16'h0504
`define STPG_RST_SPARE_C  16'h0706
`define STPG_RST_HIGH     16'h0000

`define STPG_CTRL_PAT     0
`define STPG_CTRL_FRAME   3
`define STPG_CTRL_MASK    16'h000F
`define STPG_HIGH_MASK    16'h00FF
`define STPG_LO_W         8
`define STPG_HI_W         2

`define STPG_PRBS_SEED    15'h7FFF
`define STPG_PRBS_TAP_A   14
`define STPG_PRBS_TAP_B   13

`define STPG_RESP_OKAY    2'h0
`define STPG_RESP_SLVERR  2'h2

`endif

// >>> rtl/stpg_pkg.sv
/*
 * types of the test pattern block: mode bits and the pixel word group.
 * assumes four data paths of 10-bit words.
 */
package stpg_pkg;

	localparam int STPG_PATHS  = 4;
	localparam int STPG_WORD_W = 10;
	localparam int STPG_LFSR_W = 15;

	// bit order matches the control register, pat at bit 0
	typedef struct packed {
		logic framed;
		logic prbs;
		logic inc;
		logic pat;
	} stpg_cfg_t;

	typedef struct packed {
		logic                                      fv;
		logic                                      lv;
		logic                                      dv;
		logic [STPG_PATHS-1:0][STPG_WORD_W-1:0]    data;
	} stpg_pix_t;

endpackage : stpg_pkg

// >>> rtl/stpg_top.sv
/*
 * test pattern source on the four output data paths, with an AXI4-Lite slave.
 * assumes pixel input from logic on CLK_I and a receiver that takes every word.
 */
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "stpg_map.svh"

module stpg_top (
	input  wire logic                 CLK_I,
	input  wire logic                 NRST_I,
	input  wire logic [7:0]           S_AXI_AWADDR_I,
	input  wire logic                 S_AXI_AWVALID_I,
	output logic                      S_AXI_AWREADY_O,
	input  wire logic [31:0]          S_AXI_WDATA_I,
	input  wire logic [3:0]           S_AXI_WSTRB_I,
	input  wire logic                 S_AXI_WVALID_I,
	output logic                      S_AXI_WREADY_O,
	output logic [1:0]                S_AXI_BRESP_O,
	output logic                      S_AXI_BVALID_O,
	input  wire logic                 S_AXI_BREADY_I,
	input  wire logic [7:0]           S_AXI_ARADDR_I,
	input  wire logic                 S_AXI_ARVALID_I,
	output logic                      S_AXI_ARREADY_O,
	output logic [31:0]               S_AXI_RDATA_O,
	output logic [1:0]                S_AXI_RRESP_O,
	output logic                      S_AXI_RVALID_O,
	input  wire logic                 S_AXI_RREADY_I,
	input  wire stpg_pkg::stpg_pix_t  PIX_I,
	output stpg_pkg::stpg_pix_t       PIX_O
);

	localparam int NP = stpg_pkg::STPG_PATHS;
	localparam int WW = stpg_pkg::STPG_WORD_W;
	localparam int LW = stpg_pkg::STPG_LFSR_W;
	localparam logic [31:0] RST_LOW_ALL = {`STPG_RST_LOW23, `STPG_RST_LOW01};

	// ==========================================================
	// registers
	logic [15:0]          ctrl_ff;
	logic [15:0]          lo01_ff;
	logic [15:0]          lo23_ff;
	logic [15:0]          high_ff;
	stpg_pkg::stpg_cfg_t  cfg;

	assign cfg = stpg_pkg::stpg_cfg_t'(ctrl_ff[`STPG_CTRL_FRAME:`STPG_CTRL_PAT]);

	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] d,
		input logic [3:0]  s
	);
		merge16 = old;
		if (s[0]) begin
			merge16[7:0] = d[7:0];
		end
		if (s[1]) begin
			merge16[15:8] = d[15:8];
		end
	endfunction : merge16

	// ==========================================================
	// axi write channel
	logic        awready_ff;
	logic        wready_ff;
	logic        aw_got_ff;
	logic        w_got_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic [5:0]  waddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;

	wire aw_hs       = S_AXI_AWVALID_I & awready_ff;
	wire w_hs        = S_AXI_WVALID_I & wready_ff;
	wire do_write    = aw_got_ff & w_got_ff & ~bvalid_ff;
	wire nxt_aw_got  = (aw_got_ff | aw_hs) & ~do_write;
	wire nxt_w_got   = (w_got_ff | w_hs) & ~do_write;
	wire nxt_bvalid  = do_write | (bvalid_ff & ~S_AXI_BREADY_I);
	wire nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
	wire nxt_wready  = ~nxt_w_got & ~nxt_bvalid;

	wire wr_mapped = (waddr_ff >= `STPG_IDX_CTRL) && (waddr_ff <= `STPG_IDX_STATUS);
	wire wr_ctrl   = do_write && (waddr_ff == `STPG_IDX_CTRL);
	wire wr_lo01   = do_write && (waddr_ff == `STPG_IDX_LOW01);
	wire wr_lo23   = do_write && (waddr_ff == `STPG_IDX_LOW23);
	wire wr_high   = do_write && (waddr_ff == `STPG_IDX_HIGH);
	wire [1:0] nxt_bresp = wr_mapped ? `STPG_RESP_OKAY : `STPG_RESP_SLVERR;

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `STPG_RESP_OKAY;
		end else begin
			awready_ff <= nxt_awready;
			wready_ff  <= nxt_wready;
			aw_got_ff  <= nxt_aw_got;
			w_got_ff   <= nxt_w_got;
			bvalid_ff  <= nxt_bvalid;
			if (do_write) begin
				bresp_ff <= nxt_bresp;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			waddr_ff <= 6'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else begin
			if (aw_hs) begin
				waddr_ff <= S_AXI_AWADDR_I[7:2];
			end
			if (w_hs) begin
				wdata_ff <= S_AXI_WDATA_I;
				wstrb_ff <= S_AXI_WSTRB_I;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ctrl_ff <= `STPG_RST_CTRL;
			lo01_ff <= `STPG_RST_LOW01;
			lo23_ff <= `STPG_RST_LOW23;
			high_ff <= `STPG_RST_HIGH;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff <= merge16(ctrl_ff, wdata_ff, wstrb_ff) & `STPG_CTRL_MASK;
			end
			if (wr_lo01) begin
				lo01_ff <= merge16(lo01_ff, wdata_ff, wstrb_ff);
			end
			if (wr_lo23) begin
				lo23_ff <= merge16(lo23_ff, wdata_ff, wstrb_ff);
			end
			if (wr_high) begin
				high_ff <= merge16(high_ff, wdata_ff, wstrb_ff) & `STPG_HIGH_MASK;
			end
		end
	end

	// ==========================================================
	// axi read channel
	logic        arready_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	wire        active   = cfg.pat | cfg.prbs;
	wire [15:0] status   = {13'h0000, cfg.prbs, active & ~cfg.framed, active};
	wire [5:0]  ridx     = S_AXI_ARADDR_I[7:2];
	wire        ar_hs    = S_AXI_ARVALID_I & arready_ff;
	wire        rd_hit   = (ridx >= `STPG_IDX_CTRL) && (ridx <= `STPG_IDX_STATUS);
	wire [15:0] rd_val   =
		(ridx == `STPG_IDX_CTRL)    ? ctrl_ff :
		(ridx == `STPG_IDX_SPARE_A) ? `STPG_RST_SPARE_A :
		(ridx == `STPG_IDX_LOW01)   ? lo01_ff :
		(ridx == `STPG_IDX_LOW23)   ? lo23_ff :
		(ridx == `STPG_IDX_SPARE_B) ? `STPG_RST_SPARE_B :
		(ridx == `STPG_IDX_SPARE_C) ? `STPG_RST_SPARE_C :
		(ridx == `STPG_IDX_HIGH)    ? high_ff :
		(ridx == `STPG_IDX_STATUS)  ? status : 16'h0000;
	wire nxt_rvalid  = ar_hs | (rvalid_ff & ~S_AXI_RREADY_I);
	wire nxt_arready = ~nxt_rvalid;

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= `STPG_RESP_OKAY;
		end else begin
			arready_ff <= nxt_arready;
			rvalid_ff  <= nxt_rvalid;
			if (ar_hs) begin
				rdata_ff <= {16'h0000, rd_val};
				rresp_ff <= rd_hit ? `STPG_RESP_OKAY : `STPG_RESP_SLVERR;
			end
		end
	end

	assign S_AXI_AWREADY_O = awready_ff;
	assign S_AXI_WREADY_O  = wready_ff;
	assign S_AXI_BVALID_O  = bvalid_ff;
	assign S_AXI_BRESP_O   = bresp_ff;
	assign S_AXI_ARREADY_O = arready_ff;
	assign S_AXI_RVALID_O  = rvalid_ff;
	assign S_AXI_RDATA_O   = rdata_ff;
	assign S_AXI_RRESP_O   = rresp_ff;

	// ==========================================================
	// pattern data path
	function automatic logic [LW-1:0] prbs_step(input logic [LW-1:0] q);
		logic [LW-1:0] r;
		r = q;
		for (int k = 0; k < WW; k++) begin
			r = {r[LW-2:0], r[`STPG_PRBS_TAP_A] ^ r[`STPG_PRBS_TAP_B]};
		end
		return r;
	endfunction : prbs_step

	wire [31:0] low_all  = {lo23_ff, lo01_ff};
	wire        use_prbs = cfg.prbs;
	wire        inc_mode = cfg.pat & cfg.inc & ~cfg.prbs;
	wire        emit     = active & (cfg.framed ? PIX_I.dv : 1'b1);
	wire        nxt_fv   = (active & ~cfg.framed) ? 1'b0 : PIX_I.fv;
	wire        nxt_lv   = (active & ~cfg.framed) ? 1'b0 : PIX_I.lv;
	wire        nxt_dv   = (active & ~cfg.framed) ? 1'b1 : PIX_I.dv;

	logic [NP-1:0][WW-1:0] const_word;
	logic [NP-1:0][WW-1:0] pat_word;
	logic [NP-1:0][WW-1:0] nxt_data;
	logic [NP-1:0][WW-1:0] cnt_ff;
	logic [NP-1:0][LW-1:0] lfsr_ff;
	stpg_pkg::stpg_pix_t   pix_ff;

	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_path
			localparam logic [WW-1:0] CNT_RST =
				{2'h0, RST_LOW_ALL[gi*`STPG_LO_W +: `STPG_LO_W]};
			localparam logic [LW-1:0] SEED = `STPG_PRBS_SEED ^ LW'(gi);

			assign const_word[gi] = {high_ff[gi*`STPG_HI_W +: `STPG_HI_W],
				low_all[gi*`STPG_LO_W +: `STPG_LO_W]};
			assign pat_word[gi] = use_prbs ? lfsr_ff[gi][WW-1:0] :
				(cfg.inc ? cnt_ff[gi] : const_word[gi]);
			assign nxt_data[gi] = active ? pat_word[gi] : PIX_I.data[gi];

			always_ff @(posedge CLK_I or negedge NRST_I) begin
				if (!NRST_I) begin
					cnt_ff[gi] <= CNT_RST;
				end else if (inc_mode & emit) begin
					cnt_ff[gi] <= cnt_ff[gi] + 1'b1;
				end else if (!inc_mode) begin
					cnt_ff[gi] <= const_word[gi];
				end
			end

			always_ff @(posedge CLK_I or negedge NRST_I) begin
				if (!NRST_I) begin
					lfsr_ff[gi] <= SEED;
				end else if (use_prbs & emit) begin
					lfsr_ff[gi] <= prbs_step(lfsr_ff[gi]);
				end else if (!use_prbs) begin
					lfsr_ff[gi] <= SEED;
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pix_ff <= '0;
		end else begin
			pix_ff <= {nxt_fv, nxt_lv, nxt_dv, nxt_data};
		end
	end

	assign PIX_O = pix_ff;

	// ==========================================================
	// assertions
	a_ctrl_reset_zero: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		$rose(NRST_I) |-> (ctrl_ff == `STPG_RST_CTRL) && !active)
		else $error("control not zero after reset");

	a_low_reset_vals: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		$rose(NRST_I) |-> (lo01_ff == `STPG_RST_LOW01) && (lo23_ff == `STPG_RST_LOW23))
		else $error("pattern low registers wrong after reset");

	a_pass_through: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		!active |=> (PIX_O == $past(PIX_I)))
		else $error("pixel data not passed through");

	a_const_path0: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(cfg.pat && !cfg.inc && !cfg.prbs) |=> PIX_O.data[0] ==
			$past({high_ff[0 +: `STPG_HI_W], lo01_ff[0 +: `STPG_LO_W]}))
		else $error("path 0 constant wrong");

	a_const_path2: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(cfg.pat && !cfg.inc && !cfg.prbs) |=> PIX_O.data[2] ==
			$past({high_ff[2*`STPG_HI_W +: `STPG_HI_W], lo23_ff[0 +: `STPG_LO_W]}))
		else $error("path 2 constant wrong");

	a_const_path3: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(cfg.pat && !cfg.inc && !cfg.prbs) |=> PIX_O.data[3] ==
			$past({high_ff[3*`STPG_HI_W +: `STPG_HI_W], lo23_ff[`STPG_LO_W +: `STPG_LO_W]}))
		else $error("path 3 constant wrong");

	a_inc_step: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(inc_mode && emit) ##1 (inc_mode && emit) |=>
			PIX_O.data[1] == WW'($past(PIX_O.data[1]) + 1'b1))
		else $error("incrementing pattern did not step by one");

	a_prbs_wins: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		cfg.prbs |=> PIX_O.data[2] == $past(lfsr_ff[2][WW-1:0]))
		else $error("prbs word not on output");

	a_unframed_flags: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(active && !cfg.framed) |=> !PIX_O.fv && !PIX_O.lv && PIX_O.dv)
		else $error("unframed pattern carries sync flags");

	a_framed_follow: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(active && cfg.framed) |=>
			(PIX_O.fv == $past(PIX_I.fv)) && (PIX_O.lv == $past(PIX_I.lv)) &&
			(PIX_O.dv == $past(PIX_I.dv)))
		else $error("framed pattern lost frame flags");

	a_bvalid_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("write response dropped early");

	a_rvalid_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read data dropped early");

	c_inc_run: cover property (@(posedge CLK_I) disable iff (!NRST_I)
		(inc_mode && emit) [*3]);

	c_prbs_run: cover property (@(posedge CLK_I) disable iff (!NRST_I)
		(use_prbs && emit) ##1 (use_prbs && emit));

	c_framed_gap: cover property (@(posedge CLK_I) disable iff (!NRST_I)
		(active && cfg.framed && PIX_I.dv) ##1 (active && cfg.framed && !PIX_I.dv));

	c_write_done: cover property (@(posedge CLK_I) disable iff (!NRST_I)
		wr_ctrl ##[1:4] (S_AXI_BVALID_O && S_AXI_BREADY_I));

endmodule : stpg_top

// >>> dv/stpg_rx.sv
/* downstream receiver model: takes every pixel word off the data paths.
   assumes PIX_O changes on CLK_I; arm_i marks words the bench wants judged. */
`timescale 1ns/1ps
module stpg_rx (
	input  wire logic                CLK_I,
	input  wire logic                NRST_I,
	input  wire stpg_pkg::stpg_pix_t pix_i,
	input  wire logic                arm_i,
	output stpg_pkg::stpg_pix_t      word_o,
	output logic                     got_o
);
	// ==========
	// capture
	logic arm_ff;
	// arm lags one cycle: word for a stimulus shows one edge later
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			arm_ff <= 1'b0;
			got_o  <= 1'b0;
			word_o <= '0;
		end else begin
			arm_ff <= arm_i;
			got_o  <= arm_ff;
			word_o <= pix_i;
		end
	end
endmodule : stpg_rx

// >>> dv/stpg_top_tb.sv
/* self-checking bench of stpg_top: AXI4-Lite master, pixel source, receiver.
   assumes stpg_map.svh, stpg_pkg and stpg_rx on the compile path. */
`timescale 1ns/1ps
`include "stpg_map.svh"
module stpg_top_tb;
	logic                clk, nrst, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv, arm, got;
	logic [7:0]          awa, ara;
	logic [31:0]         wd, rd;
	logic [3:0]          ws;
	logic [1:0]          br, rr;
	stpg_pkg::stpg_pix_t pin, pout, rxw;
	logic [33:0]         bq[$];
	logic [42:0]         pq[$], mq[$];
	logic [15:0]         l01, l23, hi;
	logic [15:0]         rst_v[7];
	int                  error_cnt, n_checks, seed, i;

	stpg_top DUT (.CLK_I(clk), .NRST_I(nrst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(rre), .PIX_I(pin), .PIX_O(pout));
	stpg_rx u_rx (.CLK_I(clk), .NRST_I(nrst), .pix_i(pout), .arm_i(arm), .word_o(rxw),
		.got_o(got));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==========
	// compare and verdict
	task automatic cmp_bus(logic [33:0] e, logic [33:0] g);
		n_checks++;
		if (e !== g) begin
			error_cnt++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_bus

	task automatic cmp_pix(logic [42:0] e, logic [42:0] g, logic [42:0] m);
		n_checks++;
		if ((e & m) !== (g & m)) begin
			error_cnt++;
			$display("BAD t=%0t exp=%h got=%h", $time, e & m, g & m);
		end
	endtask : cmp_pix

	task automatic print_verdict;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	// ==========
	// result watcher
	always @(posedge clk) begin
		if (bv && bre)
			cmp_bus(bq.pop_front(), {br, 32'h0});
		if (rv && rre)
			cmp_bus(bq.pop_front(), {rr, rd});
	end
	always @(negedge clk) begin
		if (got)
			cmp_pix(pq.pop_front(), rxw, mq.pop_front());
	end

	// ==========
	// bus master
	task automatic wr_reg(logic [7:0] a, logic [31:0] d, logic [1:0] r);
		int n;
		bq.push_back({r, 32'h0});
		awa <= a;
		wd  <= d;
		awv <= 1'b1;
		wv  <= 1'b1;
		bre <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
			if (bv)
				break;
		end
		bre <= 1'b0;
		@(posedge clk);
		if (n == 50) begin
			error_cnt++;
			print_verdict();
		end
	endtask : wr_reg

	task automatic rd_reg(logic [7:0] a, logic [33:0] e);
		int n;
		bq.push_back(e);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
			if (rv)
				break;
		end
		rre <= 1'b0;
		@(posedge clk);
		if (n == 50) begin
			error_cnt++;
			print_verdict();
		end
	endtask : rd_reg

	// ==========
	// pixel source; md 0 pass, 1 const, 2 framed const, 3 inc, 4 prbs flags
	function automatic logic [9:0] cv(int p);
		logic [15:0] l;
		l = (p < 2) ? l01 : l23;
		return {hi[2*p+1 -: 2], l[8*(p%2) +: 8]};
	endfunction : cv

	// prbs reference: x^15+x^14+1, one word is ten shifts
	function automatic logic [14:0] lf_step(logic [14:0] q);
		for (int s = 0; s < stpg_pkg::STPG_WORD_W; s++)
			q = {q[13:0], q[`STPG_PRBS_TAP_A] ^ q[`STPG_PRBS_TAP_B]};
		return q;
	endfunction : lf_step

	task automatic stream(int md, int cnt);
		stpg_pkg::stpg_pix_t p, e;
		logic [42:0]         m;
		logic [14:0]         lf[4];
		for (int k = 0; k < 4; k++)
			lf[k] = lf_step(lf_step(`STPG_PRBS_SEED ^ 15'(k)));
		for (int j = 0; j < cnt; j++) begin
			p = 43'({$random(seed), $random(seed)});
			e = p;
			m = '1;
			if (md != 0) begin
				if (md != 2) begin
					e.fv = 1'b0;
					e.lv = 1'b0;
					e.dv = 1'b1;
				end
				// inc and prbs start two steps past their load at this point
				for (int k = 0; k < 4; k++)
					e.data[k] = cv(k) + ((md == 3) ? 10'(j + 2) : 10'h0);
				if (md == 4)
					for (int k = 0; k < 4; k++) begin
						e.data[k] = lf[k][9:0];
						lf[k] = lf_step(lf[k]);
					end
			end
			pin <= p;
			arm <= 1'b1;
			pq.push_back(e);
			mq.push_back(m);
			@(posedge clk);
		end
		arm <= 1'b0;
	endtask : stream

	// ==========
	// main sequence
	initial begin
		{awv, wv, bre, arv, rre, arm} = '0;
		{awa, ara, wd} = '0;
		ws   = 4'hF;
		pin  = '0;
		nrst = 1'b0;
		seed = 41;
		rst_v = '{`STPG_RST_CTRL, `STPG_RST_SPARE_A, `STPG_RST_LOW01, `STPG_RST_LOW23,
			`STPG_RST_SPARE_B, `STPG_RST_SPARE_C, `STPG_RST_HIGH};
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 7; i++)
			rd_reg(8'((`STPG_IDX_CTRL + i) * 4), {18'h0, rst_v[i]});
		rd_reg(8'h5C, {18'h0, 16'h0000});
		rd_reg(8'h00, {`STPG_RESP_SLVERR, 32'h0});
		wr_reg(8'h7C, 32'h1, `STPG_RESP_SLVERR);
		wr_reg(8'h50, 32'hFFFF, `STPG_RESP_OKAY);
		rd_reg(8'h50, {18'h0, `STPG_RST_SPARE_B});
		stream(0, 8);
		l01 = 16'($random(seed));
		l23 = 16'($random(seed));
		hi  = 16'($random(seed));
		wr_reg(8'h48, {16'hFFFF, l01}, `STPG_RESP_OKAY);
		wr_reg(8'h4C, {16'h0, l23}, `STPG_RESP_OKAY);
		wr_reg(8'h58, {16'h0, hi}, `STPG_RESP_OKAY);
		hi = hi & `STPG_HIGH_MASK;
		rd_reg(8'h58, {18'h0, hi});
		wr_reg(8'h40, 32'h11, `STPG_RESP_OKAY);
		rd_reg(8'h40, {18'h0, 16'h0001});
		rd_reg(8'h5C, {18'h0, 16'h0003});
		stream(1, 8);
		wr_reg(8'h40, 32'h9, `STPG_RESP_OKAY);
		stream(2, 8);
		ws <= 4'h2;
		wr_reg(8'h48, 32'h0000AA55, `STPG_RESP_OKAY);
		ws <= 4'hF;
		rd_reg(8'h48, {18'h0, 8'hAA, l01[7:0]});
		l01 = 16'hFFFE;
		hi  = 16'h00FF;
		wr_reg(8'h48, {16'h0, l01}, `STPG_RESP_OKAY);
		wr_reg(8'h58, {16'h0, hi}, `STPG_RESP_OKAY);
		wr_reg(8'h40, 32'h3, `STPG_RESP_OKAY);
		stream(3, 8);
		wr_reg(8'h40, 32'h7, `STPG_RESP_OKAY);
		stream(4, 6);
		wr_reg(8'h40, 32'h0, `STPG_RESP_OKAY);
		stream(0, 4);
		repeat (4) @(posedge clk);
		print_verdict();
	end
endmodule : stpg_top_tb
